// File: design/dllrb_cfg.svh
// Purpose: Offsets, field positions, reset values and frame bit counts of the
//          delay-lock readback and clock configuration bank.
// Assumes: 15-bit register addresses, 8-bit registers.
// Notes:   Definitions only.
`ifndef DLLRB_CFG_SVH
`define DLLRB_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DLLRB_ADDR_W          15
`define DLLRB_OFS_STATUS      15'h0092
`define DLLRB_OFS_REQUEST     15'h0098
`define DLLRB_OFS_COARSE      15'h0099
`define DLLRB_OFS_FINE        15'h009A
`define DLLRB_OFS_PHASE       15'h009B
`define DLLRB_OFS_POLARITY    15'h009D
`define DLLRB_OFS_TEST        15'h00A0
`define DLLRB_OFS_INTERP      15'h0110

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DLLRB_BIT_LOCKED      0
`define DLLRB_BIT_LOST        1
`define DLLRB_BIT_FAIL        2
`define DLLRB_BIT_REQUEST     0
`define DLLRB_BIT_INVERT      2
`define DLLRB_BIT_DUTY        1
`define DLLRB_BIT_CROSS       0
`define DLLRB_BIT_TEST_EN     7
`define DLLRB_COARSE_W        6
`define DLLRB_FINE_W          8
`define DLLRB_PHASE_W         5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DLLRB_RST_INVERT      1'h0
`define DLLRB_RST_DUTY        1'h1
`define DLLRB_RST_CROSS       1'h1
`define DLLRB_RST_TEST_EN     1'h0
`define DLLRB_RST_TEST_DIV    2'h0
`define DLLRB_RST_LANES       4'h8
`define DLLRB_RST_INTERP      4'h1

// ----------------------------------------------------------------------
// Serial frame counts
// ----------------------------------------------------------------------
`define DLLRB_CMD_BITS        5'h10
`define DLLRB_DATA_BITS       4'h8

`endif

// File: design/dllrb_pkg.sv
// Purpose: Shared types of the delay-lock readback bank.
// Assumes: Used by the serial engine and the register bank.
// Notes:   Numbers live in dllrb_cfg.svh.
package dllrb_pkg;

  // Serial frame phases
  typedef enum logic [1:0] {
    DLLRB_IDLE,
    DLLRB_CMD,
    DLLRB_READ,
    DLLRB_WRITE
  } dllrb_state_t;

  typedef logic [14:0] dllrb_addr_t;
  typedef logic [7:0]  dllrb_byte_t;

endpackage

// File: design/dllrb_reg_if.sv
// Purpose: Register access path between serial engine and register bank.
// Assumes: One clock; wr_stb is a one-cycle pulse.
// Notes:   rdata follows addr combinationally.
`timescale 1ns/1ns
`default_nettype none
interface dllrb_reg_if;
  import dllrb_pkg::*;
  dllrb_addr_t addr;
  dllrb_byte_t wdata;
  logic        wr_stb;
  dllrb_byte_t rdata;

  modport engine (output addr, output wdata, output wr_stb, input rdata);
  modport bank   (input addr, input wdata, input wr_stb, output rdata);
endinterface
`default_nettype wire

// File: design/dllrb_spi.sv
// Purpose: Three-wire serial slave, 16-bit instruction then one data byte.
// Assumes: Serial clock far slower than ref_clk (at least 12 cycles a bit).
// Notes:   Bit 15 of the instruction set means read; MSB first.
`timescale 1ns/1ns
`default_nettype none
`include "dllrb_cfg.svh"
module dllrb_spi (
  input  wire logic      ref_clk,
  input  wire logic      reset,
  input  wire logic      spi_sclk,
  input  wire logic      spi_cs_n,
  input  wire logic      spi_sdio_in,
  output var  logic      spi_sdio_out,
  output var  logic      spi_sdio_oe,
  dllrb_reg_if.engine    regs
);
  import dllrb_pkg::*;

  logic [2:0]   s1_q, s2_q, s3_q, qual_q;
  logic         sclk_prev_q;
  logic         rise, fall, cs_act;
  dllrb_state_t state_q;
  logic [4:0]   cnt_q;
  logic [15:0]  cmd_q;
  logic [7:0]   sr_q;
  logic [3:0]   dcnt_q;

  // --------------------------------------------------------------------
  // Pin synchronisers: pins are {sclk, cs_n, sdio}
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_q   <= 3'h2;
      s2_q   <= 3'h2;
      s3_q   <= 3'h2;
      qual_q <= 3'h2;
    end else begin
      s1_q   <= {spi_sclk, spi_cs_n, spi_sdio_in};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      qual_q <= (s3_q & ~(s2_q ^ s3_q)) | (qual_q & (s2_q ^ s3_q)); // Accept once stable
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) sclk_prev_q <= 1'h0;
    else       sclk_prev_q <= qual_q[2];
  end

  assign cs_act = ~qual_q[1];
  assign rise   = cs_act & qual_q[2] & ~sclk_prev_q;
  assign fall   = cs_act & ~qual_q[2] & sclk_prev_q;

  // --------------------------------------------------------------------
  // Frame sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q      <= DLLRB_IDLE;
      cnt_q        <= 5'h00;
      cmd_q        <= 16'h0000;
      dcnt_q       <= 4'h0;
      sr_q         <= 8'h00;
      regs.addr    <= '0;
      regs.wdata   <= 8'h00;
      regs.wr_stb  <= 1'h0;
      spi_sdio_out <= 1'h0;
      spi_sdio_oe  <= 1'h0;
    end else begin
      regs.wr_stb <= 1'h0;
      if (!cs_act) begin
        state_q     <= DLLRB_IDLE;
        cnt_q       <= 5'h00;
        dcnt_q      <= 4'h0;
        spi_sdio_oe <= 1'h0;
      end else begin
        unique case (state_q)
          DLLRB_IDLE: begin
            state_q <= DLLRB_CMD;
          end
          DLLRB_CMD: if (rise) begin
            cmd_q <= {cmd_q[14:0], qual_q[0]};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == `DLLRB_CMD_BITS - 5'h01) begin
              regs.addr <= {cmd_q[13:0], qual_q[0]};
              state_q   <= cmd_q[14] ? DLLRB_READ : DLLRB_WRITE;
            end
          end
          DLLRB_READ: if (fall && dcnt_q < `DLLRB_DATA_BITS) begin
            // First falling edge loads the byte, later ones shift it
            spi_sdio_oe  <= 1'h1;
            spi_sdio_out <= (dcnt_q == 4'h0) ? regs.rdata[7] : sr_q[7];
            sr_q         <= (dcnt_q == 4'h0) ? {regs.rdata[6:0], 1'h0} : {sr_q[6:0], 1'h0};
            dcnt_q       <= dcnt_q + 4'h1;
          end else if (rise && dcnt_q == `DLLRB_DATA_BITS) begin
            spi_sdio_oe <= 1'h0;
          end
          DLLRB_WRITE: if (rise && dcnt_q < `DLLRB_DATA_BITS) begin
            sr_q   <= {sr_q[6:0], qual_q[0]};
            dcnt_q <= dcnt_q + 4'h1;
            if (dcnt_q == `DLLRB_DATA_BITS - 4'h1) begin
              regs.wdata  <= {sr_q[6:0], qual_q[0]};
              regs.wr_stb <= 1'h1;
            end
          end
        endcase
      end
    end
  end

endmodule // dllrb_spi
`default_nettype wire

// File: design/dllrb_top.sv
// Purpose: Delay-lock readback snapshots and digital clock configuration.
// Assumes: Loop values and lock flags come from logic on ref_clk.
// Notes:   Registers reached over the three-wire configuration port.
//
// Overview of operation
// - A zero-to-one write of the request bit captures coarse, fine, phase.
// - Coarse snapshot: 6 read-only bits low, upper two zero, resets zero.
// - Fine snapshot: full 8-bit read-only register, resets zero.
// - Invert bit 2 flips the digital clock polarity; resets to 0.
// - Duty-cycle correction enable in bit 1, resets to 1.
// - Cross control enable in bit 0, resets to 1.
// - Test clock output enable in bit 7, resets to 0.
// - Two-bit test clock divider select in bits 1:0, resets to 0.
// - Lane count in bits 7:4 of interpolation register, resets to 8.
// - Status shows lock achieved, lock lost, lock failed in bits 0-2.
`timescale 1ns/1ns
`default_nettype none
`include "dllrb_cfg.svh"
module dllrb_top (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          spi_sclk,
  input  wire logic                          spi_cs_n,
  input  wire logic                          spi_sdio_in,
  output var  logic                          spi_sdio_out,
  output var  logic                          spi_sdio_oe,
  input  wire logic [`DLLRB_COARSE_W-1:0]    dll_coarse_in,
  input  wire logic [`DLLRB_FINE_W-1:0]      dll_fine_in,
  input  wire logic [`DLLRB_PHASE_W-1:0]     dll_phase_in,
  input  wire logic                          dll_lock_in,
  input  wire logic                          dll_fail_in,
  input  wire logic                          dll_clk_in,
  output var  logic                          digital_clk_out,
  output var  logic                          digital_clock_invert,
  output var  logic                          duty_cycle_correct_on,
  output var  logic                          cross_control_on,
  output var  logic                          test_clk_en,
  output var  logic [1:0]                    test_clk_div,
  output var  logic                          test_clk_out,
  output var  logic [3:0]                    lane_count,
  output var  logic [3:0]                    interpolation_factor_select
);
  import dllrb_pkg::*;

  dllrb_reg_if regs ();

  logic                       req_q;
  logic                       req_prev_q;
  logic [`DLLRB_COARSE_W-1:0] coarse_delay_snapshot_q;
  logic [`DLLRB_FINE_W-1:0]   fine_delay_snapshot_q;
  logic [`DLLRB_PHASE_W-1:0]  phase_snapshot_q;
  logic                       lock_achieved_flag_q;
  logic                       lock_lost_q;
  logic                       lock_fail_q;
  logic                       locked_prev_q;
  logic [2:0]                 div_cnt_q;
  logic                       div_tick;
  logic                       wr_hit_status;

  // ----------------------------------------------------------------------
  // Serial configuration port
  // ----------------------------------------------------------------------
  // Serial engine turns frames into register reads and write strobes
  dllrb_spi u_spi (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .spi_sclk     (spi_sclk),
    .spi_cs_n     (spi_cs_n),
    .spi_sdio_in  (spi_sdio_in),
    .spi_sdio_out (spi_sdio_out),
    .spi_sdio_oe  (spi_sdio_oe),
    .regs         (regs.engine)
  );

  // ----------------------------------------------------------------------
  // Snapshot request bit and its edge history
  // ----------------------------------------------------------------------
  // Request bit as written, and its value one cycle ago
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      req_q      <= 1'h0;
      req_prev_q <= 1'h0;
    end else begin
      if (regs.wr_stb && regs.addr == `DLLRB_OFS_REQUEST)
        req_q <= regs.wdata[`DLLRB_BIT_REQUEST];
      req_prev_q <= req_q;
    end
  end

  // Capture the loop values on a rising request
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      coarse_delay_snapshot_q <= '0;
      fine_delay_snapshot_q   <= '0;
      phase_snapshot_q        <= '0;
    end else if (req_q && !req_prev_q) begin
      coarse_delay_snapshot_q <= dll_coarse_in;
      fine_delay_snapshot_q   <= dll_fine_in;
      phase_snapshot_q        <= dll_phase_in;
    end
  end

  // ----------------------------------------------------------------------
  // Lock status; lost flag is sticky, cleared by writing one
  // ----------------------------------------------------------------------
  assign wr_hit_status = regs.wr_stb && regs.addr == `DLLRB_OFS_STATUS;

  // Levels follow the loop one cycle late; loss seen against the delayed copy
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lock_achieved_flag_q <= 1'h0;
      lock_fail_q          <= 1'h0;
      locked_prev_q        <= 1'h0;
      lock_lost_q          <= 1'h0;
    end else begin
      lock_achieved_flag_q <= dll_lock_in;
      lock_fail_q          <= dll_fail_in;
      locked_prev_q        <= dll_lock_in;
      // New loss wins over a clear in the same cycle
      if (locked_prev_q && !dll_lock_in)
        lock_lost_q <= 1'h1;
      else if (wr_hit_status && regs.wdata[`DLLRB_BIT_LOST])
        lock_lost_q <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Writable configuration
  // ----------------------------------------------------------------------
  // Polarity, duty-cycle correction and cross-control enables
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      digital_clock_invert  <= `DLLRB_RST_INVERT;
      duty_cycle_correct_on <= `DLLRB_RST_DUTY;
      cross_control_on      <= `DLLRB_RST_CROSS;
    end else if (regs.wr_stb && regs.addr == `DLLRB_OFS_POLARITY) begin
      digital_clock_invert  <= regs.wdata[`DLLRB_BIT_INVERT];
      duty_cycle_correct_on <= regs.wdata[`DLLRB_BIT_DUTY];
      cross_control_on      <= regs.wdata[`DLLRB_BIT_CROSS];
    end
  end

  // Test clock enable and divider select
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      test_clk_en  <= `DLLRB_RST_TEST_EN;
      test_clk_div <= `DLLRB_RST_TEST_DIV;
    end else if (regs.wr_stb && regs.addr == `DLLRB_OFS_TEST) begin
      test_clk_en  <= regs.wdata[`DLLRB_BIT_TEST_EN];
      test_clk_div <= regs.wdata[1:0];
    end
  end

  // Lane count is stored as written; software keeps it still in operation
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lane_count                  <= `DLLRB_RST_LANES;
      interpolation_factor_select <= `DLLRB_RST_INTERP;
    end else if (regs.wr_stb && regs.addr == `DLLRB_OFS_INTERP) begin
      lane_count                  <= regs.wdata[7:4];
      interpolation_factor_select <= regs.wdata[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // Digital clock polarity
  // ----------------------------------------------------------------------
  // Registered pass-through, inverted when the invert bit is set
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) digital_clk_out <= 1'h0;
    else       digital_clk_out <= dll_clk_in ^ digital_clock_invert;
  end

  // ----------------------------------------------------------------------
  // Test clock: toggles on a divider tick every 2^div cycles
  // ----------------------------------------------------------------------
  // Free-running divider counter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) div_cnt_q <= 3'h0;
    else       div_cnt_q <= div_cnt_q + 3'h1;
  end

  // One-cycle tick every 1, 2, 4 or 8 cycles
  always_comb begin
    unique case (test_clk_div)
      2'h0: div_tick = 1'h1;
      2'h1: div_tick = (div_cnt_q[0] == 1'h1);
      2'h2: div_tick = (div_cnt_q[1:0] == 2'h3);
      2'h3: div_tick = (div_cnt_q == 3'h7);
    endcase
  end

  // Toggle on each tick while enabled, parked low otherwise
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)              test_clk_out <= 1'h0;
    else if (!test_clk_en)  test_clk_out <= 1'h0;
    else if (div_tick)      test_clk_out <= ~test_clk_out;
  end

  // ----------------------------------------------------------------------
  // Read multiplexer; unmapped and reserved bits read zero
  // ----------------------------------------------------------------------
  // Address decode of the read data, live from the registers
  always_comb begin
    unique case (regs.addr)
      `DLLRB_OFS_STATUS:   regs.rdata = {5'h00, lock_fail_q, lock_lost_q,
                                         lock_achieved_flag_q};
      `DLLRB_OFS_REQUEST:  regs.rdata = {7'h00, req_q};
      `DLLRB_OFS_COARSE:   regs.rdata = {2'h0, coarse_delay_snapshot_q};
      `DLLRB_OFS_FINE:     regs.rdata = fine_delay_snapshot_q;
      `DLLRB_OFS_PHASE:    regs.rdata = {3'h0, phase_snapshot_q};
      `DLLRB_OFS_POLARITY: regs.rdata = {5'h00, digital_clock_invert,
                                         duty_cycle_correct_on, cross_control_on};
      `DLLRB_OFS_TEST:     regs.rdata = {test_clk_en, 5'h00, test_clk_div};
      `DLLRB_OFS_INTERP:   regs.rdata = {lane_count, interpolation_factor_select};
      default:             regs.rdata = 8'h00;
    endcase
  end

endmodule // dllrb_top
`default_nettype wire

// File: testbench/dllrb_top_properties.sv
// Purpose: Port-level properties of the delay-lock readback bank.
// Assumes: Serial pins follow the frame timing of the serial port.
// Notes:   Bound to dllrb_top after the module.
`timescale 1ns/1ns
`default_nettype none
module dllrb_checker (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       spi_cs_n,
  input wire logic       spi_sdio_oe,
  input wire logic       dll_clk_in,
  input wire logic       digital_clk_out,
  input wire logic       digital_clock_invert,
  input wire logic       duty_cycle_correct_on,
  input wire logic       cross_control_on,
  input wire logic       test_clk_en,
  input wire logic [1:0] test_clk_div,
  input wire logic       test_clk_out,
  input wire logic [3:0] lane_count,
  input wire logic [3:0] interpolation_factor_select
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  reset_values_a: assert property (
    $past(reset) |-> !digital_clock_invert && duty_cycle_correct_on && cross_control_on
      && !test_clk_en && test_clk_div == 2'h0 && lane_count == 4'h8
      && interpolation_factor_select == 4'h1)
    else $error("configuration not at reset value after reset");
  clk_polarity_a: assert property (
    !$past(reset) |-> digital_clk_out == ($past(dll_clk_in) ^ $past(digital_clock_invert)))
    else $error("digital clock polarity wrong");
  test_off_a: assert property (
    (!test_clk_en)[*2] |-> !test_clk_out)
    else $error("test clock active while disabled");
  test_div0_a: assert property (
    (test_clk_en && test_clk_div == 2'h0)[*3] |-> $changed(test_clk_out))
    else $error("test clock not toggling every cycle");
  test_div3_a: assert property (
    $rose(test_clk_out) && test_clk_div == 2'h3 && $past(test_clk_div, 8) == 2'h3
      |-> (test_clk_out || !test_clk_en)[*8] ##1 !test_clk_out)
    else $error("test clock high time wrong for divide three");
  oe_idle_a: assert property (
    spi_cs_n[*8] |-> !spi_sdio_oe)
    else $error("data line driven while not selected");
  oe_start_a: assert property (
    $fell(spi_cs_n) |-> (!spi_sdio_oe)[*8])
    else $error("data line driven at frame start");
  config_hold_a: assert property (
    spi_cs_n[*8] |-> $stable(lane_count) && $stable(interpolation_factor_select)
      && $stable(test_clk_en) && $stable(test_clk_div) && $stable(digital_clock_invert))
    else $error("configuration changed outside a frame");
endmodule // dllrb_checker

bind dllrb_top dllrb_checker u_dllrb_checker (
  .ref_clk, .reset, .spi_cs_n, .spi_sdio_oe, .dll_clk_in, .digital_clk_out,
  .digital_clock_invert, .duty_cycle_correct_on, .cross_control_on, .test_clk_en,
  .test_clk_div, .test_clk_out, .lane_count, .interpolation_factor_select
);
`default_nettype wire

// File: testbench/dll_readback_clock_config_test.sv
// Purpose: Self-checking bench for the delay-lock readback bank.
// Assumes: Serial half period HP cycles, well above the minimum of 6.
// Notes:   Registers are written only through three-wire frames.
`timescale 1ns/1ns
`default_nettype none
`include "dllrb_cfg.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module dll_readback_clock_config_test;
  import dllrb_pkg::*;
  localparam int HP = 10;
  logic       ref_clk = 1'b0, reset = 1'b1, spi_sclk = 1'b0, spi_cs_n = 1'b1;
  logic       spi_sdio_in = 1'b0, dll_lock_in = 1'b1, dll_fail_in = 1'b0;
  logic       dll_clk_in = 1'b0, spi_sdio_out, spi_sdio_oe, digital_clk_out;
  logic       digital_clock_invert, duty_cycle_correct_on, cross_control_on;
  logic       test_clk_en, test_clk_out;
  logic [1:0] test_clk_div;
  logic [3:0] lane_count, interpolation_factor_select;
  logic [5:0] dll_coarse_in = 6'h2A;
  logic [7:0] dll_fine_in = 8'hC3;
  logic [4:0] dll_phase_in = 5'h15;
  int         err_total = 0, cmp_count = 0;

  dllrb_top u_dllrb_top (
    .ref_clk, .reset, .spi_sclk, .spi_cs_n, .spi_sdio_in, .spi_sdio_out, .spi_sdio_oe,
    .dll_coarse_in, .dll_fine_in, .dll_phase_in, .dll_lock_in, .dll_fail_in,
    .dll_clk_in, .digital_clk_out, .digital_clock_invert, .duty_cycle_correct_on,
    .cross_control_on, .test_clk_en, .test_clk_div, .test_clk_out, .lane_count,
    .interpolation_factor_select
  );

  // ----------------------------------------------------------------
  // Clock, loop clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    dll_clk_in <= ~dll_clk_in;
  end
  initial begin
    repeat (50000) @(posedge ref_clk);
    $display("[FAIL] watchdog expected finish seen hang");
    err_total++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One frame: read flag, 15-bit address, one data byte, MSB first
  task automatic xfer(input logic is_rd, input dllrb_addr_t a, input dllrb_byte_t d,
                      output dllrb_byte_t q);
    logic [23:0] f;
    f = {is_rd, a, d};
    q = 8'h00;
    spi_cs_n <= 1'b0;
    tick(HP);
    for (int i = 23; i >= 0; i--) begin
      spi_sclk    <= 1'b0;
      spi_sdio_in <= f[i];
      tick(HP - 1);
      @(negedge ref_clk);
      if (is_rd && i < 8) begin
        q[i] = spi_sdio_out;
        `CHK("drive enable", 1'b1, spi_sdio_oe)
      end
      tick(1);
      spi_sclk <= 1'b1;
      tick(HP);
    end
    spi_sclk <= 1'b0;
    tick(HP);
    spi_cs_n <= 1'b1;
    tick(HP);
  endtask

  task automatic wr(input dllrb_addr_t a, input dllrb_byte_t d);
    dllrb_byte_t q;
    xfer(1'b0, a, d, q);
  endtask

  task automatic rd(input string nm, input dllrb_addr_t a, input dllrb_byte_t e);
    dllrb_byte_t q;
    xfer(1'b1, a, 8'h00, q);
    `CHK(nm, e, q)
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int   n;
    logic last;
    tick(2);
    reset <= 1'b0;
    tick(6);
    // Reset values and an unmapped place
    rd("coarse", `DLLRB_OFS_COARSE, 8'h00);
    rd("fine", `DLLRB_OFS_FINE, 8'h00);
    rd("phase", `DLLRB_OFS_PHASE, 8'h00);
    rd("polarity", `DLLRB_OFS_POLARITY, 8'h03);
    rd("test", `DLLRB_OFS_TEST, 8'h00);
    rd("interp", `DLLRB_OFS_INTERP, 8'h81);
    rd("request", `DLLRB_OFS_REQUEST, 8'h00);
    rd("unmapped", 15'h00FF, 8'h00);
    $display("test reset_values done");
    // Capture on a rising request only; the coarse snapshot ignores a write
    wr(`DLLRB_OFS_REQUEST, 8'h01);
    rd("coarse", `DLLRB_OFS_COARSE, 8'h2A);
    rd("fine", `DLLRB_OFS_FINE, 8'hC3);
    rd("phase", `DLLRB_OFS_PHASE, 8'h15);
    dll_coarse_in <= 6'h3F;
    dll_fine_in   <= 8'h3C;
    dll_phase_in  <= 5'h1F;
    wr(`DLLRB_OFS_COARSE, 8'hFF);
    wr(`DLLRB_OFS_REQUEST, 8'h01);
    rd("coarse held", `DLLRB_OFS_COARSE, 8'h2A);
    rd("request", `DLLRB_OFS_REQUEST, 8'h01);
    wr(`DLLRB_OFS_REQUEST, 8'h00);
    wr(`DLLRB_OFS_REQUEST, 8'h01);
    rd("coarse new", `DLLRB_OFS_COARSE, 8'h3F);
    rd("fine new", `DLLRB_OFS_FINE, 8'h3C);
    rd("phase new", `DLLRB_OFS_PHASE, 8'h1F);
    $display("test snapshot done");
    // Lock flags: achieved, lost after drop, failure, then clear of lost
    rd("status", `DLLRB_OFS_STATUS, 8'h01);
    dll_lock_in   <= 1'b0;
    dll_fail_in   <= 1'b1;
    rd("status lost", `DLLRB_OFS_STATUS, 8'h06);
    wr(`DLLRB_OFS_STATUS, 8'h02);
    rd("status clear", `DLLRB_OFS_STATUS, 8'h04);
    $display("test status done");
    // Loop clock toggles every cycle; the output lags it by one cycle
    @(negedge ref_clk);
    `CHK("clock normal", ~dll_clk_in, digital_clk_out)
    tick(1);
    // Polarity bits, reserved bits read zero
    wr(`DLLRB_OFS_POLARITY, 8'hFF);
    rd("polarity", `DLLRB_OFS_POLARITY, 8'h07);
    wr(`DLLRB_OFS_POLARITY, 8'h04);
    `CHK("invert", 1'b1, digital_clock_invert)
    `CHK("duty", 1'b0, duty_cycle_correct_on)
    `CHK("cross", 1'b0, cross_control_on)
    @(negedge ref_clk);
    `CHK("clock inverted", dll_clk_in, digital_clk_out)
    tick(1);
    // Every divider: toggles counted over 32 cycles
    for (int k = 0; k < 4; k++) begin
      wr(`DLLRB_OFS_TEST, 8'hFC | 8'(k));
      rd("test", `DLLRB_OFS_TEST, 8'h80 | 8'(k));
      `CHK("test div", 2'(k), test_clk_div)
      n = 0;
      @(negedge ref_clk);
      last = test_clk_out;
      repeat (32) begin
        @(negedge ref_clk);
        if (test_clk_out !== last) n++;
        last = test_clk_out;
      end
      `CHK("test toggles", 32 >> k, n)
      tick(1);
    end
    wr(`DLLRB_OFS_TEST, 8'h00);
    `CHK("test enable", 1'b0, test_clk_en)
    $display("test clock_config done");
    // Lane count written as 4 while interpolation select steps through 0 to 6
    for (int k = 0; k < 7; k++) begin
      wr(`DLLRB_OFS_INTERP, 8'h40 | 8'(k));
      `CHK("interp", 4'(k), interpolation_factor_select)
      `CHK("lanes", 4'h4, lane_count)
    end
    rd("interp", `DLLRB_OFS_INTERP, 8'h46);
    $display("test interpolation done");
    test_done();
  end
endmodule // dll_readback_clock_config_test
`default_nettype wire
